// ---- inc/sct_defines.svh ----
// Register offsets, field positions and reset values of the slow clock timer
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH
`define SCT_ADDR_W        16
`define SCT_OFF_CLKCTL    16'h5065
`define SCT_OFF_CTL       16'h50C0
`define SCT_OFF_CNT       16'h50C1
`define SCT_OFF_CMP       16'h50C2
`define SCT_OFF_IMSK      16'h50C3
`define SCT_OFF_IFLG      16'h50C4
`define SCT_OFF_DUTY      16'h50C5
`define SCT_BIT_GATE      0
`define SCT_BIT_DIV_LO    1
`define SCT_BIT_DIV_HI    3
`define SCT_BIT_RUN       0
`define SCT_BIT_MODE      1
`define SCT_BIT_CLR       4
`define SCT_BIT_IE        0
`define SCT_BIT_IF        0
`define SCT_DIV_MAX       3'h5
`define SCT_DIV_RST       3'h0
`define SCT_CMP_RST       8'h00
`define SCT_DUTY_RST      8'h00
`define SCT_PRE_W         5
`endif

// ---- inc/sct_pkg.sv ----
// Types of the slow clock timer
package sct_pkg;
    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } sct_bus_t;
    // Whole state of the timer
    typedef struct packed {
        logic [2:0] div_sel;
        logic       gate;
        logic       mode;
        logic       run;
        logic [7:0] cnt;
        logic [7:0] cmp;
        logic [7:0] duty;
        logic       ie;
        logic       flag;
        logic [4:0] pre;
        logic       osc_q;
        logic       pwm;
        logic       pin;
        logic       irq;
        logic       match;
        logic [7:0] rdata;
    } sct_state_t;
endpackage : sct_pkg

// ---- logic/sct_timer.sv ----
// Slow clock 8-bit compare / PWM timer with byte register port
// How it works
// - Divide slow clock by 1..32 per select
// - Gate bit blocks or passes count clock
// - Repeat mode: match clears counter, continues
// - One-shot mode: match clears, then stops
// - In halt, one-shot does not stop
// - Writing clear bit forces counter zero
// - Compare register resets zero, match clears
// - Match period is compare plus one ticks
// - Run bit starts/stops, counter retained
// - Run with clear: clear then count
// - PWM high above duty, low after compare
// - Duty above compare keeps PWM low
// - Match sets flag, flag and enable interrupt
// - Pin carries PWM only when routed
// - Clock control: divider D3-1, gate D0
// - Eight-bit up-counter compared twice
// - Clear bit write-only, reads zero
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`include "sct_defines.svh"

module sct_timer
(
    input  wire logic        ref_clk,      // System clock, 100 MHz
    input  wire logic        rst,          // Asynchronous reset, high
    input  wire logic        osc_clk,      // Slow oscillator, sampled
    input  wire logic        cpu_halt,     // Processor in halt state
    input  wire logic        pin_sel_pwm,  // Port routes timer to pin
    input  wire logic        gpio_out,     // GPIO value for shared pin
    input  wire logic [15:0] bus_addr,     // Register address
    input  wire logic [7:0]  bus_wdata,    // Write data
    input  wire logic        bus_wr,       // Write strobe
    input  wire logic        bus_rd,       // Read strobe
    output logic      [7:0]  bus_rdata,    // Read data, cycle after rd
    output logic             pwm_output_pin, // Shared pin level
    output logic             irq,          // Interrupt request
    output logic             match_pulse   // One-cycle compare match
);

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    sct_pkg::sct_state_t st_r;    // Current state
    sct_pkg::sct_state_t st_nxt;  // Next state
    sct_pkg::sct_bus_t   bus;     // Bundled bus request

    logic       osc_rise;         // Rising edge of slow clock
    logic       tick;             // Divided, gated count tick
    logic       match_now;        // Counter equals compare value
    logic       wr_ctl;           // Write to timer control
    logic       stop_one;         // One-shot stop at match
    logic [4:0] pre_inc;          // Prescaler plus one

    assign bus = '{addr: bus_addr, wdata: bus_wdata,
                   wr: bus_wr, rd: bus_rd};

    // Divider tap: one tick per 2^sel slow edges, 32 for sel 5 to 7
    function automatic logic div_tap(input logic [2:0] sel,
                                     input logic [4:0] pre);
        logic [4:0] mask;
        mask = 5'h00;
        case (sel)
            3'h0:    mask = 5'h00;
            3'h1:    mask = 5'h01;
            3'h2:    mask = 5'h03;
            3'h3:    mask = 5'h07;
            3'h4:    mask = 5'h0F;
            default: mask = 5'h1F;
        endcase
        div_tap = ((pre & mask) == mask);
    endfunction : div_tap

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt   = st_r;
        osc_rise = osc_clk & ~st_r.osc_q;
        st_nxt.osc_q = osc_clk;
        pre_inc  = st_r.pre + 5'h01;
        // Gate low holds the divider idle to save power
        tick = st_r.gate & osc_rise
             & div_tap(st_r.div_sel, st_r.pre);
        if (!st_r.gate)
        begin
            st_nxt.pre = 5'h00;
        end
        else if (osc_rise)
        begin
            st_nxt.pre = pre_inc;
        end
        match_now = (st_r.cnt == st_r.cmp);
        wr_ctl    = bus.wr && (bus.addr == `SCT_OFF_CTL);
        stop_one  = st_r.mode && !cpu_halt;
        st_nxt.match = 1'b0;

        // Counting on ticks while running
        if (st_r.run && tick)
        begin
            if (match_now)
            begin
                st_nxt.cnt   = 8'h00;
                st_nxt.match = 1'b1;
                st_nxt.flag  = 1'b1;
                if (stop_one)
                begin
                    st_nxt.run = 1'b0;
                end
            end
            else
            begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end

        // PWM: rise past duty, fall at compare clear
        if (st_r.run && tick)
        begin
            if (match_now)
            begin
                st_nxt.pwm = 1'b0;
            end
            else if (st_r.cnt == st_r.duty
                     && st_r.duty <= st_r.cmp)
            begin
                st_nxt.pwm = 1'b1;
            end
        end
        if (st_r.duty > st_r.cmp)
        begin
            st_nxt.pwm = 1'b0;
        end

        // Register writes
        if (bus.wr)
        begin
            unique case (bus.addr)
                `SCT_OFF_CLKCTL:
                begin
                    st_nxt.gate    = bus.wdata[`SCT_BIT_GATE];
                    st_nxt.div_sel =
                        bus.wdata[`SCT_BIT_DIV_HI:`SCT_BIT_DIV_LO];
                end
                `SCT_OFF_CTL:
                begin
                    st_nxt.mode = bus.wdata[`SCT_BIT_MODE];
                    st_nxt.run  = bus.wdata[`SCT_BIT_RUN];
                    if (bus.wdata[`SCT_BIT_CLR])
                    begin
                        st_nxt.cnt = 8'h00;
                        st_nxt.pwm = 1'b0;
                    end
                end
                `SCT_OFF_CMP:  st_nxt.cmp  = bus.wdata;
                `SCT_OFF_IMSK: st_nxt.ie   = bus.wdata[`SCT_BIT_IE];
                `SCT_OFF_IFLG:
                begin
                    // A match in the same cycle keeps the flag set
                    if (bus.wdata[`SCT_BIT_IF] && !st_nxt.match)
                    begin
                        st_nxt.flag = 1'b0;
                    end
                end
                `SCT_OFF_DUTY: st_nxt.duty = bus.wdata;
                default: ;
            endcase
        end

        // Register reads, reserved bits zero
        st_nxt.rdata = 8'h00;
        if (bus.rd)
        begin
            unique case (bus.addr)
                `SCT_OFF_CLKCTL:
                    st_nxt.rdata = {4'h0, st_r.div_sel, st_r.gate};
                `SCT_OFF_CTL:
                    st_nxt.rdata = {6'h00, st_r.mode, st_r.run};
                `SCT_OFF_CNT:  st_nxt.rdata = st_r.cnt;
                `SCT_OFF_CMP:  st_nxt.rdata = st_r.cmp;
                `SCT_OFF_IMSK: st_nxt.rdata = {7'h00, st_r.ie};
                `SCT_OFF_IFLG: st_nxt.rdata = {7'h00, st_r.flag};
                `SCT_OFF_DUTY: st_nxt.rdata = st_r.duty;
                default:       st_nxt.rdata = 8'h00;
            endcase
        end

        st_nxt.irq = st_nxt.flag & st_nxt.ie;
        // Shared pin defaults to GPIO
        st_nxt.pin = pin_sel_pwm ? st_nxt.pwm : gpio_out;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r         <= '0;
            st_r.div_sel <= `SCT_DIV_RST;
            st_r.cmp     <= `SCT_CMP_RST;
            st_r.duty    <= `SCT_DUTY_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata      = st_r.rdata;
    assign pwm_output_pin = st_r.pin;
    assign irq            = st_r.irq;
    assign match_pulse    = st_r.match;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Every check lives in the system clock domain and sleeps
    // through reset, so one default clock and disable serve all
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // A closed gate must starve the counter of ticks
    gate_blocks_a: assert property (
        !st_r.gate |=> !match_pulse || $past(st_r.gate))
        else $error("match without gate");

    // A match returns the counter to zero; a control write in the same
    // cycle is left out of the check, though it also leaves zero
    match_clears_a: assert property (
        match_pulse && !$past(wr_ctl) |-> st_r.cnt == 8'h00)
        else $error("match did not clear counter");

    // Repeat mode keeps running across a match
    repeat_runs_a: assert property (
        match_pulse && !$past(st_r.mode) && !$past(bus.wr)
        |-> st_r.run)
        else $error("repeat mode stopped");

    // One-shot mode drops the run bit at its first match
    oneshot_stop_a: assert property (
        match_pulse && $past(st_r.mode) && !$past(cpu_halt)
        && !$past(wr_ctl) |-> !st_r.run)
        else $error("one-shot kept running");

    // A halted processor defeats the automatic stop; this is a
    // known limitation that software has to live with
    halt_keeps_a: assert property (
        match_pulse && $past(cpu_halt) && !$past(wr_ctl)
        |-> st_r.run)
        else $error("halt one-shot stopped");

    // Clear bit zeroes the counter, run bit lands in one write
    clear_zero_a: assert property (
        wr_ctl && bus.wdata[`SCT_BIT_CLR] |=> st_r.cnt == 8'h00
        && st_r.run == $past(bus.wdata[`SCT_BIT_RUN]))
        else $error("clear or run write failed");

    // A stopped counter keeps its value for a later resume
    stop_hold_a: assert property (
        !st_r.run && !wr_ctl |=> $stable(st_r.cnt))
        else $error("stopped counter moved");

    // Without a qualified tick or a control write the counter must not move
    no_tick_a: assert property (
        !(st_r.run && tick) && !wr_ctl |=> $stable(st_r.cnt))
        else $error("counter moved without tick");

    // A qualified tick below the compare value adds exactly one
    count_up_a: assert property (
        st_r.run && tick && !match_now && !wr_ctl
        |=> st_r.cnt == $past(st_r.cnt) + 8'h01)
        else $error("counter did not step by one");

    // Every match leaves the flag set behind it
    flag_set_a: assert property (
        match_pulse |-> st_r.flag)
        else $error("match did not set flag");

    // Request is the masked flag, nothing more
    irq_gate_a: assert property (
        irq == (st_r.flag && st_r.ie))
        else $error("irq not flag and enable");

    // Duty above compare pins the waveform low
    duty_low_a: assert property (
        $past(st_r.duty) > $past(st_r.cmp) |-> !st_r.pwm)
        else $error("pwm high with duty above compare");

    // Clear bit and reserved bits of control always read zero
    ctl_read_a: assert property (
        bus.rd && bus.addr == `SCT_OFF_CTL
        |=> bus_rdata[7:2] == 6'h00)
        else $error("reserved control bits read nonzero");

    // Without routing the pin follows the port value
    pin_route_a: assert property (
        !pin_sel_pwm |=> pwm_output_pin == $past(gpio_out))
        else $error("pin not gpio");

    // ------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------
    match_seen_c: cover property (@(posedge ref_clk) match_pulse);
    pwm_high_c:   cover property (@(posedge ref_clk) $rose(st_r.pwm));
    irq_c:        cover property (@(posedge ref_clk) $rose(irq));
    oneshot_c:    cover property (@(posedge ref_clk)
        match_pulse && !st_r.run);

endmodule : sct_timer

// ---- tb/testbench.sv ----
// Self-checking bench for the slow clock compare / PWM timer
`timescale 1ns/10ps
`include "sct_defines.svh"

module testbench;
    // ------------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------------
    logic        ref_clk, rst, osc_clk, cpu_halt;  // Clock, reset, stimulus
    logic        pin_sel_pwm, gpio_out;            // Shared pin routing
    logic [15:0] bus_addr;                         // Register address
    logic [7:0]  bus_wdata, bus_rdata;             // Register data
    logic        bus_wr, bus_rd;                   // Register strobes
    logic        pwm_output_pin, irq, match_pulse; // Observed outputs
    int          err_total, cmp_count, match_cnt;  // Bookkeeping

    sct_timer dut (.ref_clk(ref_clk), .rst(rst), .osc_clk(osc_clk),
        .cpu_halt(cpu_halt), .pin_sel_pwm(pin_sel_pwm),
        .gpio_out(gpio_out), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .pwm_output_pin(pwm_output_pin), .irq(irq),
        .match_pulse(match_pulse));

    // Free-running system clock, 10 ns period
    always #5 ref_clk = ~ref_clk;

    // Tally of compare-match pulses, one per cycle seen high
    always @(posedge ref_clk)
        if (match_pulse === 1'b1)
            match_cnt <= match_cnt + 1;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string      w,
                       input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge ref_clk);
        bus_wr    <= 1'b0;
    endtask : wr

    // Read data is only valid in the cycle after the strobe
    task automatic rd(input logic [15:0] a,
                      input logic [7:0]  e,
                      input string       w);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge ref_clk);
        bus_rd   <= 1'b0;
        #1 chk(w, e, bus_rdata);
    endtask : rd

    // Slow edges held long enough for the edge detector to see each one
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            osc_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            osc_clk <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask : ticks

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [15:0] a [8];
        a = '{`SCT_OFF_CLKCTL, `SCT_OFF_CTL, `SCT_OFF_CNT, `SCT_OFF_CMP,
              `SCT_OFF_IMSK, `SCT_OFF_IFLG, `SCT_OFF_DUTY, 16'h50C6};
        foreach (a[i])
            rd(a[i], 8'h00, "reset value");
        chk("irq idle", 8'h00, {7'h00, irq});
    endtask : t_reset

    // Match counts are taken against a baseline, so the tally
    // process stays the only writer after time zero
    task automatic t_repeat();
        int m0;
        wr(`SCT_OFF_CMP, 8'h03);
        wr(`SCT_OFF_IFLG, 8'h01);
        wr(`SCT_OFF_IMSK, 8'h01);
        wr(`SCT_OFF_CLKCTL, 8'h01);
        wr(`SCT_OFF_CTL, 8'h11);
        m0 = match_cnt;
        ticks(6);
        rd(`SCT_OFF_CNT, 8'h02, "count after 6");
        chk("matches", 8'h01, 8'(match_cnt - m0));
        chk("irq set", 8'h01, {7'h00, irq});
        rd(`SCT_OFF_IFLG, 8'h01, "flag set");
        wr(`SCT_OFF_IFLG, 8'h01);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 8'h00, {7'h00, irq});
        ticks(2);
        chk("second match", 8'h02, 8'(match_cnt - m0));
        wr(`SCT_OFF_IMSK, 8'h00);
        wr(`SCT_OFF_IFLG, 8'h01);
        ticks(4);
        rd(`SCT_OFF_IFLG, 8'h01, "flag masked");
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(`SCT_OFF_CTL, 8'h00);
    endtask : t_repeat

    task automatic t_oneshot();
        int m0;
        wr(`SCT_OFF_CTL, 8'h02);
        wr(`SCT_OFF_CMP, 8'h02);
        wr(`SCT_OFF_CTL, 8'h13);
        m0 = match_cnt;
        ticks(6);
        chk("one match", 8'h01, 8'(match_cnt - m0));
        rd(`SCT_OFF_CNT, 8'h00, "one-shot count");
        rd(`SCT_OFF_CTL, 8'h02, "run dropped");
        // Halted processor defeats the automatic stop
        @(posedge ref_clk);
        cpu_halt <= 1'b1;
        wr(`SCT_OFF_CMP, 8'h01);
        wr(`SCT_OFF_CTL, 8'h13);
        ticks(4);
        chk("halt matches", 8'h03, 8'(match_cnt - m0));
        rd(`SCT_OFF_CTL, 8'h03, "still running");
        @(posedge ref_clk);
        cpu_halt <= 1'b0;
        wr(`SCT_OFF_CTL, 8'h00);
    endtask : t_oneshot

    task automatic t_stop();
        wr(`SCT_OFF_CMP, 8'hFF);
        wr(`SCT_OFF_CTL, 8'h11);
        ticks(5);
        wr(`SCT_OFF_CTL, 8'h00);
        ticks(3);
        rd(`SCT_OFF_CNT, 8'h05, "held count");
        wr(`SCT_OFF_CTL, 8'h01);
        ticks(2);
        rd(`SCT_OFF_CNT, 8'h07, "resumed count");
        wr(`SCT_OFF_CTL, 8'h10);
        rd(`SCT_OFF_CNT, 8'h00, "clear bit");
    endtask : t_stop

    task automatic t_pwm();
        logic exp_pwm;
        wr(`SCT_OFF_CMP, 8'h03);
        wr(`SCT_OFF_DUTY, 8'h01);
        pin_sel_pwm <= 1'b1;
        wr(`SCT_OFF_CTL, 8'h11);
        // High while the count sits above the duty value
        for (int k = 1; k <= 8; k++)
        begin
            ticks(1);
            exp_pwm = ((k % 4) >= 2);
            chk("pwm level", 8'(exp_pwm), 8'(pwm_output_pin));
        end
        pin_sel_pwm <= 1'b0;
        gpio_out    <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("gpio on pin", 8'h01, {7'h00, pwm_output_pin});
        pin_sel_pwm <= 1'b1;
        wr(`SCT_OFF_DUTY, 8'h05);
        for (int k = 1; k <= 8; k++)
        begin
            ticks(1);
            chk("pwm stuck low", 8'h00, 8'(pwm_output_pin));
        end
        wr(`SCT_OFF_CTL, 8'h00);
    endtask : t_pwm

    task automatic t_div();
        wr(`SCT_OFF_CMP, 8'hFF);
        wr(`SCT_OFF_CLKCTL, 8'h00);
        wr(`SCT_OFF_CTL, 8'h11);
        ticks(3);
        rd(`SCT_OFF_CNT, 8'h00, "gate closed");
        // Every ratio: two count ticks need 2 << r slow edges;
        // the reserved codes fall back to the slowest ratio
        for (int d = 0; d <= 7; d++)
        begin
            int r;
            r = (d > 5) ? 5 : d;
            wr(`SCT_OFF_CLKCTL, 8'h00);
            wr(`SCT_OFF_CLKCTL, {4'h0, d[2:0], 1'b1});
            rd(`SCT_OFF_CLKCTL, {4'h0, d[2:0], 1'b1}, "clkctl");
            wr(`SCT_OFF_CTL, 8'h11);
            ticks(2 << r);
            rd(`SCT_OFF_CNT, 8'h02, "divided count");
        end
        wr(`SCT_OFF_CTL, 8'h00);
    endtask : t_div

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // The sequence needs about 2900 cycles; allow a wide margin
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        end_sim();
    end

    initial
    begin
        {ref_clk, osc_clk, cpu_halt, pin_sel_pwm, gpio_out} = 5'h00;
        {bus_addr, bus_wdata, bus_wr, bus_rd} = 26'h0;
        {err_total, cmp_count, match_cnt} = 0;
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_repeat();
        t_oneshot();
        t_stop();
        t_pwm();
        t_div();
        end_sim();
    end
endmodule : testbench
